//--- core/dcoctl_top.sv
/*
 * dco numerator control: register port, dpll deviation stepping and the
 * apll offset feed. assumes a single 25 MHz clock and a master that keeps
 * read and write strobes one cycle long and never both at once.
 */
`timescale 1ns/100ps

// What this block does
// - deviation word is an unsigned 38-bit value
// - denominator value zero stands for two to the fortieth
// - holdover offset word is signed 40-bit two's complement
// - apll denominator is fixed at two to the fortieth
// - apll steering works only with the loop path and fraction set
// - history off: effective numerator equals base plus full offset at once
// - effective apll numerator is readable at any time
// - history on: offset fed gradually by step size and step period
// - a new offset write drops remaining steps and feeds the new value
// - history on: completion flag sets once the offset is fully fed
// - deviation word is added to or subtracted from feedback numerator
// - step write of 0 raises frequency, 1 lowers it
// - dco mode off clears offset and restores the numerator
module dcoctl_top
	import dcoctl_pkg::*;
(
	input wire logic CLK_SYS_I,                       // 25 MHz clock
	input wire logic RESET_I,                         // sync reset, high
	input wire logic [ADDR_W-1:0] ADDR_I,             // register byte address
	input wire logic [DATA_W-1:0] WR_DATA_I,          // write data
	input wire logic WR_I,                            // write strobe
	input wire logic RD_I,                            // read strobe
	output logic [DATA_W-1:0] RD_DATA_O,              // read data, next cycle
	output logic [NUM_W-1:0] DPLL_FB_NUMERATOR_O,     // effective dpll numerator
	output logic [NUM_W-1:0] APLL_EFF_NUMERATOR_O,    // effective apll numerator
	output logic FEED_DONE_O                          // sticky feed complete flag
);

	// ****************************************
	// register state
	// ****************************************
	logic [CTRL_W-1:0] ctrl_q;
	logic [DEV_W-1:0] dev_q;
	logic [NUM_W-1:0] fbn_q;
	logic [NUM_W-1:0] den_q;
	logic [NUM_W-1:0] base_q;
	logic [NUM_W-1:0] ofs_q;
	logic [DATA_W-1:0] ofs_lo_q;
	logic [STEP_W-1:0] ssize_q;
	logic [PER_W-1:0] sper_q;
	logic load_q;
	logic step_q;
	logic dir_q;
	logic done_q;
	logic [DATA_W-1:0] rd_d;
	logic [DATA_W-1:0] rd_q;
	logic steer_en;
	logic feed_done;
	logic feed_busy;
	logic [NUM_W-1:0] fb_num;
	logic [NUM_W-1:0] apll_num;
	logic [NUM_W:0] den_eff;

	// address match for a write
	function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
		return WR_I && (ADDR_I == a);
	endfunction

	// low word of a 40-bit value
	function automatic logic [DATA_W-1:0] lo_w(input logic [NUM_W-1:0] v);
		return v[DATA_W-1:0];
	endfunction

	// high bits of a 40-bit value, zero extended
	function automatic logic [DATA_W-1:0] hi_w(input logic [NUM_W-1:0] v);
		return DATA_W'(v[NUM_W-1:DATA_W]);
	endfunction

	// ****************************************
	// writable registers
	// ****************************************

	// control bits
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			ctrl_q <= CTRL_RST;
		end else if (wr_hit(A_CTRL)) begin
			ctrl_q <= WR_DATA_I[CTRL_W-1:0];
		end
	end

	a_ctrl_write: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
		(WR_I && ADDR_I == A_CTRL) |=> (ctrl_q == $past(WR_DATA_I[CTRL_W-1:0])))
		else $error("control write lost");

	// dpll deviation word, 38 bits unsigned
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			dev_q <= '0;
		end else if (wr_hit(A_DEV_LO)) begin
			dev_q[DATA_W-1:0] <= WR_DATA_I;
		end else if (wr_hit(A_DEV_HI)) begin
			dev_q[DEV_W-1:DATA_W] <= WR_DATA_I[DEV_W-DATA_W-1:0];
		end
	end

	a_dev_high: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
		(WR_I && ADDR_I == A_DEV_HI) |=> (dev_q[DEV_W-1:DATA_W] == $past(WR_DATA_I[DEV_W-DATA_W-1:0])))
		else $error("deviation high bits lost");

	// dpll feedback numerator and denominator
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			fbn_q <= '0;
			den_q <= '0;
		end else begin
			if (wr_hit(A_FBN_LO)) begin
				fbn_q[DATA_W-1:0] <= WR_DATA_I;
			end
			if (wr_hit(A_FBN_HI)) begin
				fbn_q[NUM_W-1:DATA_W] <= WR_DATA_I[NUM_W-DATA_W-1:0];
			end
			if (wr_hit(A_DEN_LO)) begin
				den_q[DATA_W-1:0] <= WR_DATA_I;
			end
			if (wr_hit(A_DEN_HI)) begin
				den_q[NUM_W-1:DATA_W] <= WR_DATA_I[NUM_W-DATA_W-1:0];
			end
		end
	end

	a_fbn_high: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
		(WR_I && ADDR_I == A_FBN_HI) |=> (fbn_q[NUM_W-1:DATA_W] == $past(WR_DATA_I[NUM_W-DATA_W-1:0])))
		else $error("feedback numerator high bits lost");
	a_den_zero: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
		(!RESET_I && den_q == '0) |=> den_eff[NUM_W])
		else $error("zero denominator not widened");

	// apll base numerator
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			base_q <= '0;
		end else if (wr_hit(A_BASE_LO)) begin
			base_q[DATA_W-1:0] <= WR_DATA_I;
		end else if (wr_hit(A_BASE_HI)) begin
			base_q[NUM_W-1:DATA_W] <= WR_DATA_I[NUM_W-DATA_W-1:0];
		end
	end

	a_base_high: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
		(WR_I && ADDR_I == A_BASE_HI) |=> (base_q[NUM_W-1:DATA_W] == $past(WR_DATA_I[NUM_W-DATA_W-1:0])))
		else $error("base numerator high bits lost");

	// offset word: low half is staged, the high half write commits both
	// so the feed never sees a half-updated signed value
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			ofs_lo_q <= '0;
			ofs_q <= '0;
			load_q <= 1'b0;
		end else begin
			load_q <= wr_hit(A_OFS_HI);
			if (wr_hit(A_OFS_LO)) begin
				ofs_lo_q <= WR_DATA_I;
			end
			if (wr_hit(A_OFS_HI)) begin
				ofs_q <= {WR_DATA_I[NUM_W-DATA_W-1:0], ofs_lo_q};
			end
		end
	end

	a_ofs_stage: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
		(WR_I && ADDR_I == A_OFS_LO) |=> (!load_q && ofs_q == $past(ofs_q)))
		else $error("low offset half leaked early");
	a_ofs_high: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
		(WR_I && ADDR_I == A_OFS_HI) |=> (ofs_q[NUM_W-1:DATA_W] == $past(WR_DATA_I[NUM_W-DATA_W-1:0])))
		else $error("offset sign bits lost");

	// feed step size and period
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			ssize_q <= SSIZE_RST;
			sper_q <= SPER_RST;
		end else begin
			if (wr_hit(A_SSIZE)) begin
				ssize_q <= STEP_W'(WR_DATA_I);
			end
			if (wr_hit(A_SPER)) begin
				sper_q <= WR_DATA_I[PER_W-1:0];
			end
		end
	end

	a_period_write: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
		(WR_I && ADDR_I == A_SPER) |=> (sper_q == $past(WR_DATA_I[PER_W-1:0])))
		else $error("step period write lost");
	a_size_write: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
		(WR_I && ADDR_I == A_SSIZE) |=> (ssize_q == STEP_W'($past(WR_DATA_I))))
		else $error("step size write lost");

	// dco step request, direction taken from the written bit
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			step_q <= 1'b0;
			dir_q <= 1'b0;
		end else begin
			step_q <= wr_hit(A_STEP) && ctrl_q[B_DCO_EN];
			if (wr_hit(A_STEP)) begin
				dir_q <= WR_DATA_I[B_DIR];
			end
		end
	end

	a_step_gated: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
		(WR_I && ADDR_I == A_STEP && !ctrl_q[B_DCO_EN]) |=> !step_q)
		else $error("step taken while dco mode off");
	a_step_dir: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
		(WR_I && ADDR_I == A_STEP) |=> (dir_q == $past(WR_DATA_I[B_DIR])))
		else $error("step direction lost");

	// completion flag: set wins over a same-cycle write-one clear
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			done_q <= 1'b0;
		end else if (feed_done) begin
			done_q <= 1'b1;
		end else if (wr_hit(A_FLAGS) && WR_DATA_I[B_DONE]) begin
			done_q <= 1'b0;
		end
	end

	a_flag_clear: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
		(WR_I && ADDR_I == A_FLAGS && WR_DATA_I[B_DONE] && !feed_done) |=> !done_q)
		else $error("completion flag not cleared");

	// ****************************************
	// steering paths
	// ****************************************

	// apll steering needs the loop path and the 40-bit fraction mode
	assign steer_en = ctrl_q[B_LOOP] && ctrl_q[B_FRAC];

	// dpll deviation accumulator
	dcoctl_fbacc u_fbacc (
		.clk_i(CLK_SYS_I),
		.reset_i(RESET_I),
		.en_i(ctrl_q[B_DCO_EN]),
		.step_i(step_q),
		.dir_i(dir_q),
		.dev_i(dev_q),
		.base_i(fbn_q),
		.den_i(den_q),
		.num_o(fb_num),
		.den_o(den_eff)
	);

	// apll offset feed
	dcoctl_ramp u_ramp (
		.clk_i(CLK_SYS_I),
		.reset_i(RESET_I),
		.en_i(steer_en),
		.history_i(ctrl_q[B_HISTORY]),
		.load_i(load_q),
		.offset_i(ofs_q),
		.base_i(base_q),
		.step_i(ssize_q),
		.period_i(sper_q),
		.eff_o(apll_num),
		.done_o(feed_done),
		.busy_o(feed_busy)
	);

	// ****************************************
	// read side
	// ****************************************

	// read mux; unmapped addresses read zero
	always_comb begin
		rd_d = '0;
		unique case (ADDR_I)
			A_CTRL: rd_d = DATA_W'(ctrl_q);
			A_DEV_LO: rd_d = dev_q[DATA_W-1:0];
			A_DEV_HI: rd_d = DATA_W'(dev_q[DEV_W-1:DATA_W]);
			A_FBN_LO: rd_d = lo_w(fbn_q);
			A_FBN_HI: rd_d = hi_w(fbn_q);
			A_FBE_LO: rd_d = lo_w(fb_num);
			A_FBE_HI: rd_d = hi_w(fb_num);
			A_DEN_LO: rd_d = lo_w(den_q);
			A_DEN_HI: rd_d = hi_w(den_q);
			A_BASE_LO: rd_d = lo_w(base_q);
			A_BASE_HI: rd_d = hi_w(base_q);
			A_OFS_LO: rd_d = lo_w(ofs_q);
			A_OFS_HI: rd_d = hi_w(ofs_q);
			A_SSIZE: rd_d = ssize_q[DATA_W-1:0];
			A_SPER: rd_d = DATA_W'(sper_q);
			A_STAT_LO: rd_d = lo_w(apll_num);
			A_STAT_HI: rd_d = hi_w(apll_num);
			A_FLAGS: rd_d = DATA_W'({feed_busy, done_q});
			A_DENE_HI: rd_d = DATA_W'(den_eff[NUM_W:DATA_W]);
			default: rd_d = '0;
		endcase
	end

	// read data register, valid only in the cycle after the strobe
	always_ff @(posedge CLK_SYS_I) begin
		if (RESET_I) begin
			rd_q <= '0;
		end else begin
			rd_q <= RD_I ? rd_d : '0;
		end
	end

	a_read_idle: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
		!RD_I |=> (RD_DATA_O == '0))
		else $error("read data outside its cycle");

	// outputs straight from flip-flops
	assign RD_DATA_O = rd_q;
	assign DPLL_FB_NUMERATOR_O = fb_num;
	assign APLL_EFF_NUMERATOR_O = apll_num;
	assign FEED_DONE_O = done_q;

	// ****************************************
	// checks
	// ****************************************

	a_flag_set_wins: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
		feed_done |=> done_q)
		else $error("completion flag lost");
	a_status_read: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
		(RD_I && ADDR_I == A_STAT_LO) |=> (RD_DATA_O == $past(apll_num[DATA_W-1:0])))
		else $error("status read mismatch");
	a_steer_gate: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
		(!steer_en ##1 !steer_en) |=> (APLL_EFF_NUMERATOR_O == $past(base_q)))
		else $error("apll steered while gated");
	a_commit_load: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
		(WR_I && ADDR_I == A_OFS_HI) |=> (load_q && ofs_q[DATA_W-1:0] == $past(ofs_lo_q)))
		else $error("offset commit missing");
endmodule

//--- inc/dcoctl_pkg.sv
/*
 * shared constants of the dco numerator control block: register map,
 * field positions, widths, reset values and the feed state encoding.
 * assumes a 32-bit plain register port on the block's single clock.
 */
package dcoctl_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int DEV_W = 38;   // dco deviation word, unsigned
	localparam int NUM_W = 40;   // numerators, offset word, denominators
	localparam int STEP_W = 40;  // feed step size
	localparam int PER_W = 24;   // feed step period, in clock cycles
	localparam int CTRL_W = 5;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] A_STEP = 8'h04;
	localparam logic [ADDR_W-1:0] A_DEV_LO = 8'h08;
	localparam logic [ADDR_W-1:0] A_DEV_HI = 8'h0C;
	localparam logic [ADDR_W-1:0] A_FBN_LO = 8'h10;
	localparam logic [ADDR_W-1:0] A_FBN_HI = 8'h14;
	localparam logic [ADDR_W-1:0] A_FBE_LO = 8'h18;
	localparam logic [ADDR_W-1:0] A_FBE_HI = 8'h1C;
	localparam logic [ADDR_W-1:0] A_DEN_LO = 8'h20;
	localparam logic [ADDR_W-1:0] A_DEN_HI = 8'h24;
	localparam logic [ADDR_W-1:0] A_BASE_LO = 8'h28;
	localparam logic [ADDR_W-1:0] A_BASE_HI = 8'h2C;
	localparam logic [ADDR_W-1:0] A_OFS_LO = 8'h30;
	localparam logic [ADDR_W-1:0] A_OFS_HI = 8'h34;
	localparam logic [ADDR_W-1:0] A_SSIZE = 8'h38;
	localparam logic [ADDR_W-1:0] A_SPER = 8'h3C;
	localparam logic [ADDR_W-1:0] A_STAT_LO = 8'h40;
	localparam logic [ADDR_W-1:0] A_STAT_HI = 8'h44;
	localparam logic [ADDR_W-1:0] A_FLAGS = 8'h48;
	localparam logic [ADDR_W-1:0] A_DENE_HI = 8'h4C;

	// ****************************************
	// field positions
	// ****************************************
	localparam int B_DCO_EN = 0;     // dco_mode_enable
	localparam int B_HISTORY = 1;    // history_enable
	localparam int B_LOOP = 2;       // loop_path_enable
	localparam int B_FRAC = 3;       // fraction_mode
	localparam int B_DIG = 4;        // digital_loop_enable
	localparam int B_DIR = 0;        // dco_step_update direction
	localparam int B_DONE = 0;       // feed complete flag
	localparam int B_BUSY = 1;       // feed in progress

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam logic [STEP_W-1:0] SSIZE_RST = 40'h00_0000_0001;
	localparam logic [PER_W-1:0] SPER_RST = 24'h00_0001;
	localparam logic [PER_W-1:0] PER_ONE = 24'h00_0001;

	// feed state, one-hot
	typedef enum logic [1:0] {
		RMP_IDLE = 2'b01,
		RMP_FEED = 2'b10
	} dcoctl_ramp_e;

endpackage

//--- core/dcoctl_fbacc.sv
/*
 * dpll dco accumulator: steps a deviation word onto the feedback numerator.
 * assumes step pulses from the register port on the same clock.
 */
`timescale 1ns/100ps
module dcoctl_fbacc
	import dcoctl_pkg::*;
(
	input wire logic clk_i,                 // system clock
	input wire logic reset_i,               // sync reset, high
	input wire logic en_i,                  // dco mode enable
	input wire logic step_i,                // one-cycle step request
	input wire logic dir_i,                 // 0 up, 1 down
	input wire logic [DEV_W-1:0] dev_i,     // deviation word
	input wire logic [NUM_W-1:0] base_i,    // programmed numerator
	input wire logic [NUM_W-1:0] den_i,     // programmed denominator
	output logic [NUM_W-1:0] num_o,         // effective numerator
	output logic [NUM_W:0] den_o            // effective denominator
);
	logic [NUM_W-1:0] acc_q;

	// accumulated offset, cleared when dco mode drops
	always_ff @(posedge clk_i) begin
		if (reset_i || !en_i) begin
			acc_q <= '0;
		end else if (step_i) begin
			if (dir_i) begin
				acc_q <= acc_q - NUM_W'(dev_i);
			end else begin
				acc_q <= acc_q + NUM_W'(dev_i);
			end
		end
	end

	// effective numerator and denominator
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			num_o <= '0;
			den_o <= '0;
		end else begin
			num_o <= base_i + acc_q;
			den_o <= (den_i == '0) ? {1'b1, {NUM_W{1'b0}}} : {1'b0, den_i};
		end
	end

	a_step_up: assert property (@(posedge clk_i) disable iff (reset_i)
		(en_i && step_i && !dir_i) |=> (acc_q == $past(acc_q) + NUM_W'($past(dev_i))))
		else $error("up step not applied");
	a_off_clear: assert property (@(posedge clk_i) disable iff (reset_i)
		(!en_i ##1 !en_i) |=> (num_o == $past(base_i)))
		else $error("numerator not restored");
endmodule

//--- core/dcoctl_ramp.sv
/*
 * apll offset feed: applies the signed offset at once or in timed steps.
 * assumes load pulses and settings from the register port, same clock.
 */
`timescale 1ns/100ps
module dcoctl_ramp
	import dcoctl_pkg::*;
(
	input wire logic clk_i,                 // system clock
	input wire logic reset_i,               // sync reset, high
	input wire logic en_i,                  // steering allowed
	input wire logic history_i,             // 1 stepped feed, 0 absolute
	input wire logic load_i,                // new offset written
	input wire logic [NUM_W-1:0] offset_i,  // signed offset word
	input wire logic [NUM_W-1:0] base_i,    // base numerator
	input wire logic [STEP_W-1:0] step_i,   // step size
	input wire logic [PER_W-1:0] period_i,  // step period in cycles
	output logic [NUM_W-1:0] eff_o,         // effective numerator
	output logic done_o,                    // one-cycle completion
	output logic busy_o                     // feed running
);
	dcoctl_ramp_e state_q;
	logic [NUM_W-1:0] fed_q;
	logic [PER_W-1:0] cnt_q;
	logic signed [NUM_W:0] rem;
	logic [NUM_W:0] mag;
	logic tick, last;

	// remaining distance and whether one step covers it
	always_comb begin
		rem = $signed({offset_i[NUM_W-1], offset_i}) - $signed({fed_q[NUM_W-1], fed_q});
		mag = rem[NUM_W] ? (NUM_W+1)'(-rem) : (NUM_W+1)'(rem);
		last = (mag <= {1'b0, step_i});
		tick = (cnt_q == '0);
	end

	// feed state
	always_ff @(posedge clk_i) begin
		if (reset_i || !en_i) begin
			state_q <= RMP_IDLE;
		end else begin
			unique case (state_q)
				RMP_IDLE: begin
					if (load_i && history_i) begin
						state_q <= RMP_FEED;
					end
				end
				RMP_FEED: begin
					if (load_i && history_i) begin
						state_q <= RMP_FEED;
					end else if (!history_i || (tick && last)) begin
						state_q <= RMP_IDLE;
					end
				end
			endcase
		end
	end

	// step period counter, restarted on each load
	always_ff @(posedge clk_i) begin
		if (reset_i || load_i || state_q != RMP_FEED || tick) begin
			cnt_q <= (period_i == '0) ? '0 : period_i - PER_ONE;
		end else begin
			cnt_q <= cnt_q - PER_ONE;
		end
	end

	// amount of the offset fed so far
	always_ff @(posedge clk_i) begin
		if (reset_i || !en_i) begin
			fed_q <= '0;
		end else if (!history_i) begin
			fed_q <= offset_i;
		end else if (state_q == RMP_FEED && tick && !load_i) begin
			if (last) begin
				fed_q <= offset_i;
			end else if (rem[NUM_W]) begin
				fed_q <= fed_q - NUM_W'(step_i);
			end else begin
				fed_q <= fed_q + NUM_W'(step_i);
			end
		end
	end

	// outputs; sum wraps modulo the fixed power-of-two denominator
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			eff_o <= '0;
			done_o <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			eff_o <= base_i + fed_q;
			done_o <= en_i && history_i && state_q == RMP_FEED && tick && last && !load_i;
			busy_o <= state_q == RMP_FEED;
		end
	end

	a_abs_apply: assert property (@(posedge clk_i) disable iff (reset_i)
		(en_i && !history_i) |=> (fed_q == $past(offset_i)))
		else $error("absolute offset not applied");
	a_feed_land: assert property (@(posedge clk_i) disable iff (reset_i)
		done_o |-> (fed_q == $past(offset_i)))
		else $error("feed did not land on offset");
	a_reload_feed: assert property (@(posedge clk_i) disable iff (reset_i)
		(en_i && history_i && load_i) |=> (state_q == RMP_FEED && fed_q == $past(fed_q)))
		else $error("reload did not restart feed");
	a_period_hold: assert property (@(posedge clk_i) disable iff (reset_i)
		(en_i && history_i && !load_i && state_q == RMP_FEED && !tick) |=> (fed_q == $past(fed_q)))
		else $error("fed moved between ticks");
endmodule

//--- test/dcoctl_top_tb.sv
/*
 * self-checking bench for the dco numerator control block: dpll deviation
 * stepping, denominator zero reading, apll absolute and stepped offset feed.
 * assumes the register map and timing of dcoctl_pkg and a 25 MHz clock.
 */
`timescale 1ns/100ps
module dcoctl_top_tb
	import dcoctl_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [31:0] rdata;
	logic [39:0] fbnum;
	logic [39:0] effnum;
	logic done;
	int n_fail = 0;
	int checked = 0;
	logic [39:0] seen[$];
	int at[$];
	localparam logic [39:0] BASE = 40'hAB_1234_5678;
	localparam logic [39:0] BASE2 = 40'h10_0000_0000;

	// 25 MHz system clock
	always #20 clk = ~clk;

	dcoctl_top dut (
		.CLK_SYS_I(clk),
		.RESET_I(rst),
		.ADDR_I(addr),
		.WR_DATA_I(wdata),
		.WR_I(wr_s),
		.RD_I(rd_s),
		.RD_DATA_O(rdata),
		.DPLL_FB_NUMERATOR_O(fbnum),
		.APLL_EFF_NUMERATOR_O(effnum),
		.FEED_DONE_O(done)
	);

	// ****************************************
	// bus and compare helpers
	// ****************************************
	task automatic chk(input string nm, input logic [39:0] ex, input logic [39:0] got);
		checked++;
		if (got !== ex) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// one-cycle write strobe, gap cycle before it so calls may follow at once
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic wr40(input logic [7:0] a, input logic [39:0] v);
		wr(a, v[31:0]);
		wr(a + 8'h04, {24'h00_0000, v[39:32]});
	endtask

	task automatic rd40(input logic [7:0] a, output logic [39:0] v);
		logic [31:0] lo;
		logic [31:0] hi;
		rd(a, lo);
		rd(a + 8'h04, hi);
		v = {hi[7:0], lo};
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// record every change of the apll output until the done flag or the limit
	task automatic feed(input int lim);
		logic [39:0] last;
		last = effnum;
		seen.delete();
		at.delete();
		for (int i = 0; i < lim; i++) begin
			cyc(1);
			if (effnum !== last) begin
				seen.push_back(effnum);
				at.push_back(i);
				last = effnum;
			end
			if (done === 1'b1) break;
		end
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		logic [31:0] d;
		chk("dpll num at reset", 40'h0, fbnum);
		chk("apll num at reset", 40'h0, effnum);
		rd(A_CTRL, d);
		chk("ctrl reset", 40'(CTRL_RST), 40'(d));
		rd(A_SSIZE, d);
		chk("step size reset", SSIZE_RST, 40'(d));
		cyc(1);
		chk("read data idle", 40'h0, 40'(rdata));
		rd(A_SPER, d);
		chk("step period reset", 40'(SPER_RST), 40'(d));
		wr(A_STAT_LO, 32'hFFFF_FFFF);
		rd(A_STAT_LO, d);
		chk("status read only", 40'h0, 40'(d));
		wr(8'hF0, 32'h1234_5678);
		rd(8'hF0, d);
		chk("unmapped", 40'h0, 40'(d));
	endtask

	task automatic t_dco();
		logic [39:0] dev;
		logic [39:0] v;
		dev = 40'h3F_FFFF_FFFF;
		wr40(A_FBN_LO, BASE);
		wr40(A_DEV_LO, dev);
		wr(A_CTRL, 32'h0000_0001);
		wr(A_STEP, 32'h0000_0000);
		cyc(4);
		chk("dco step up", BASE + dev, fbnum);
		wr(A_STEP, 32'h0000_0001);
		wr(A_STEP, 32'h0000_0001);
		cyc(4);
		chk("dco step down", BASE - dev, fbnum);
		rd40(A_FBE_LO, v);
		chk("dco readback", BASE - dev, v);
		wr(A_CTRL, 32'h0000_0000);
		cyc(4);
		chk("dco off restores", BASE, fbnum);
		wr(A_STEP, 32'h0000_0000);
		cyc(4);
		chk("step while off", BASE, fbnum);
	endtask

	task automatic t_den();
		logic [31:0] d;
		wr40(A_DEN_LO, 40'h0);
		rd(A_DENE_HI, d);
		chk("den zero is 2^40", 40'h100, 40'(d));
		wr40(A_DEN_LO, 40'h5);
		rd(A_DENE_HI, d);
		chk("den five", 40'h0, 40'(d));
	endtask

	task automatic t_abs();
		logic [39:0] v;
		wr40(A_BASE_LO, BASE2);
		wr(A_CTRL, 32'h0000_000C);
		wr40(A_OFS_LO, 40'hFF_FFFF_FFFD);
		cyc(4);
		chk("absolute negative", BASE2 - 40'h3, effnum);
		rd40(A_STAT_LO, v);
		chk("status readback", BASE2 - 40'h3, v);
		wr(A_CTRL, 32'h0000_0004);
		cyc(4);
		chk("fraction off", BASE2, effnum);
		wr(A_CTRL, 32'h0000_000C);
		cyc(4);
		chk("steering back", BASE2 - 40'h3, effnum);
		wr40(A_OFS_LO, 40'h0);
		cyc(4);
	endtask

	task automatic t_rel();
		logic [31:0] d;
		wr(A_SSIZE, 32'h0000_0004);
		wr(A_SPER, 32'h0000_0003);
		wr(A_CTRL, 32'h0000_000E);
		wr(A_FLAGS, 32'h0000_0001);
		wr(A_OFS_LO, 32'h0000_000A);
		wr(A_OFS_HI, 32'h0000_0000);
		feed(100);
		chk("step count", 40'h3, 40'(seen.size()));
		if (seen.size() == 3) begin
			chk("first step", BASE2 + 40'h4, seen[0]);
			chk("second step", BASE2 + 40'h8, seen[1]);
			chk("step period", 40'h3, 40'(at[1] - at[0]));
		end
		chk("clamped end", BASE2 + 40'hA, effnum);
		chk("done pin", 40'h1, 40'(done));
		rd(A_FLAGS, d);
		chk("done flag", 40'h1, 40'(d));
		wr(A_FLAGS, 32'h0000_0001);
		rd(A_FLAGS, d);
		chk("done cleared", 40'h0, 40'(d));
	endtask

	task automatic t_restart();
		logic [39:0] mid;
		logic [39:0] mx;
		logic [31:0] d;
		wr(A_SSIZE, 32'h0000_0001);
		wr(A_SPER, 32'h0000_0002);
		wr(A_OFS_LO, 32'h0000_0064);
		wr(A_OFS_HI, 32'h0000_0000);
		cyc(12);
		mid = effnum;
		chk("feed under way", 40'h1, 40'(mid > BASE2 + 40'hA && mid < BASE2 + 40'h64));
		chk("no early done", 40'h0, 40'(done));
		wr(A_OFS_LO, 32'h0000_0005);
		wr(A_OFS_HI, 32'h0000_0000);
		rd(A_FLAGS, d);
		chk("busy during feed", 40'h2, 40'(d));
		feed(400);
		mx = mid;
		foreach (seen[i]) if (seen[i] > mx) mx = seen[i];
		chk("old steps dropped", 40'h1, 40'(mx <= mid + 40'h4));
		chk("new target", BASE2 + 40'h5, effnum);
		chk("done after new", 40'h1, 40'(done));
	endtask

	// ****************************************
	// sequence, watchdog and verdict
	// ****************************************
	task automatic conclude();
		if (n_fail == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		cyc(1);
		t_reset();
		t_dco();
		t_den();
		t_abs();
		t_rel();
		t_restart();
		conclude();
	end

	// the whole run needs about 200 cycles
	initial begin
		#800000;
		n_fail++;
		conclude();
	end
endmodule
